/* File: hdl/cmp_access_check.sv */
// Purpose: Combinational access decision for memory accesses
// Assumes: Mode and window values stable within the cycle
// Notes: Purely combinational, registered by the caller
`timescale 1ns/10ps
module cmp_access_check
   import cmp_pkg::*;
(
   input wire cmp_mode_t mode,
   input wire logic [15:0] addr,
   input wire logic wr,
   input wire logic fetch,
   input wire logic integrity_fn,
   input wire logic [15:0] xch_base,
   input wire logic [15:0] xch_size,
   input wire logic [2:0] user_rights,
   input wire logic seg_enabled,
   output logic allow
);
   function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   logic rom_fw, rom_app, ee_fw, ee_app, ram_fw, ram_app, in_xch;
   logic [16:0] xch_end;

   always_comb begin
      rom_fw = in_rng(addr, ROM_FW_LO, ROM_FW_HI);
      rom_app = in_rng(addr, ROM_APP_LO, ROM_APP_HI);
      ee_fw = in_rng(addr, EE_FW_LO, EE_FW_HI);
      ee_app = in_rng(addr, EE_APP_LO, EE_APP_HI);
      ram_fw = in_rng(addr, RAM_FW_LO, RAM_FW_HI);
      ram_app = in_rng(addr, RAM_APP_LO, RAM_APP_HI);
      xch_end = {1'b0, xch_base} + {1'b0, xch_size};
      in_xch = ram_app && (addr >= xch_base) && ({1'b0, addr} < xch_end);
      allow = 1'b0;
      case (mode)
         MODE_BOOT, MODE_TEST: begin
            allow = !(wr && (rom_fw || rom_app));
         end
         MODE_FW: begin
            // Firmware partitioned from application memory
            if (rom_fw) begin
               allow = !wr;
            end else if (ee_app) begin
               allow = integrity_fn && !fetch;
            end else if (ee_fw) begin
               allow = 1'b1;
            end else if (ram_fw) begin
               allow = !fetch;
            end else if (in_xch) begin
               allow = !fetch;
            end else begin
               allow = 1'b0;
            end
         end
         MODE_SYS: begin
            if (rom_app) begin
               allow = !wr;
            end else begin
               allow = ee_app || ram_app;
            end
         end
         MODE_USER: begin
            // Rights from segment entry; table may sit in writable segment
            if (!seg_enabled) begin
               allow = 1'b0;
            end else if (rom_app || ee_app || ram_app) begin
               allow = (wr ? user_rights[1] : user_rights[2]) &&
                       (!fetch || user_rights[0]) && !(rom_app && wr);
            end else begin
               allow = 1'b0;
            end
         end
         default: begin
            allow = 1'b0;
         end
      endcase
   end
endmodule : cmp_access_check

/* File: hdl/cmp_mode_ctrl.sv */
// Purpose: CPU mode tracking, special register protection, access gating
// Assumes: CPU presents one access per cycle with a valid strobe
// Notes: Outputs registered; grant follows the request by one edge
`timescale 1ns/10ps
module cmp_mode_ctrl
   import cmp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_fetch,
   input wire logic [15:0] mem_wdata,
   input wire logic integrity_fn,
   input wire logic [2:0] seg_rights,
   input wire logic sfr_req,
   input wire cmp_reg_t sfr_sel,
   input wire logic sfr_wr,
   input wire logic [15:0] sfr_wdata,
   input wire logic call_req,
   input wire logic [15:0] call_target,
   input wire logic long_call_instr,
   input wire logic absolute_call_instr,
   input wire logic extended_call_instr,
   input wire logic exc_req,
   input wire cmp_mode_t exc_mode,
   input wire logic return_from_interrupt_instr,
   output logic mem_grant,
   output logic mem_refuse,
   output logic [15:0] mem_wdata_out,
   output logic mem_we_out,
   output logic sfr_grant,
   output logic sfr_refuse,
   output logic [15:0] sfr_rdata,
   output cmp_mode_t cpu_mode,
   output logic [15:0] seg_table_base,
   output logic [15:0] xch_base,
   output logic [15:0] xch_size,
   output logic ee_size_limit_en,
   output logic cx_size_limit_en,
   output logic cipher_en,
   output logic bignum_en
);
   cmp_mode_t mode_reg, mode_next;
   cmp_mode_t ret_stack_reg [STACK_DEPTH];
   logic [1:0] sp_reg;
   logic [15:0] seg_base_reg, xch_base_reg, xch_size_reg;
   logic [3:0] feat_reg, perm_off_reg;
   logic mem_ok, sfr_ok, sfr_do_wr, seg_enabled;

   // ----------------------------------------
   // Memory access decision
   // ----------------------------------------
   assign seg_enabled = (seg_base_reg != SEG_BASE_RST);

   cmp_access_check u_chk (
      .mode(mode_reg),
      .addr(mem_addr),
      .wr(mem_wr),
      .fetch(mem_fetch),
      .integrity_fn(integrity_fn),
      .xch_base(xch_base_reg),
      .xch_size(xch_size_reg),
      .user_rights(seg_rights),
      .seg_enabled(seg_enabled),
      .allow(mem_ok)
   );

   // ----------------------------------------
   // Special register permission
   // ----------------------------------------
   function automatic logic sfr_allowed(input cmp_mode_t m, input cmp_reg_t r,
                                        input logic w);
      sfr_allowed = 1'b0;
      case (r)
         REG_SEG_BASE: sfr_allowed = (m == MODE_SYS);
         REG_CSR: sfr_allowed = (m == MODE_SYS) || (m == MODE_BOOT) ||
                                (m == MODE_TEST) || !w;
         REG_XCH_BASE, REG_XCH_SIZE: sfr_allowed = (m == MODE_SYS) || (!w && m == MODE_FW);
         REG_FEAT: sfr_allowed = (m == MODE_SYS) || (m == MODE_BOOT) || (m == MODE_TEST);
         default: sfr_allowed = 1'b0;
      endcase
   endfunction : sfr_allowed

   assign sfr_ok = sfr_allowed(mode_reg, sfr_sel, sfr_wr);
   assign sfr_do_wr = sfr_req && sfr_wr && sfr_ok;

   // ----------------------------------------
   // Mode transitions
   // ----------------------------------------
   always_comb begin
      mode_next = mode_reg;
      if (exc_req) begin
         mode_next = exc_mode;
      end else if (return_from_interrupt_instr && sp_reg != 2'h0) begin
         mode_next = ret_stack_reg[sp_reg - 2'h1];
      end else if (call_req && call_target == SYS_CALL_VEC) begin
         mode_next = MODE_SYS;
      end else if (call_req && call_target == FW_CALL_VEC) begin
         mode_next = MODE_FW;
      end else if (call_req && call_target == SPECIAL_CALL_ADDR &&
                   (long_call_instr || absolute_call_instr || extended_call_instr)) begin
         mode_next = MODE_FW;
      end else if (sfr_do_wr && sfr_sel == REG_CSR) begin
         case (sfr_wdata[CSR_MODE_LSB +: 3])
            3'h0: mode_next = MODE_BOOT;
            3'h1: mode_next = MODE_TEST;
            3'h2: mode_next = MODE_FW;
            3'h3: mode_next = MODE_SYS;
            3'h4: mode_next = MODE_USER;
            default: mode_next = mode_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_reg <= MODE_BOOT;
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sp_reg <= 2'h0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            ret_stack_reg[i] <= MODE_BOOT;
         end
      end else if (exc_req) begin
         ret_stack_reg[sp_reg] <= mode_reg;
         if (sp_reg != 2'h3) begin
            sp_reg <= sp_reg + 2'h1;
         end
      end else if (return_from_interrupt_instr && sp_reg != 2'h0) begin
         sp_reg <= sp_reg - 2'h1;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         seg_base_reg <= SEG_BASE_RST;
         xch_base_reg <= XCH_BASE_RST;
         xch_size_reg <= XCH_SIZE_RST;
      end else if (sfr_do_wr) begin
         if (sfr_sel == REG_SEG_BASE) begin
            seg_base_reg <= sfr_wdata;
         end else if (sfr_sel == REG_XCH_BASE) begin
            xch_base_reg <= sfr_wdata;
         end else if (sfr_sel == REG_XCH_SIZE) begin
            xch_size_reg <= sfr_wdata;
         end
      end
   end

   // Low nibble enables, high nibble sets sticky permanent disable
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         feat_reg <= FEAT_RST;
         perm_off_reg <= 4'h0;
      end else if (sfr_do_wr && sfr_sel == REG_FEAT) begin
         feat_reg <= sfr_wdata[3:0];
         perm_off_reg <= perm_off_reg | sfr_wdata[FEAT_PERM_LSB +: 4];
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_grant <= 1'b0;
         mem_refuse <= 1'b0;
         mem_we_out <= 1'b0;
         mem_wdata_out <= 16'h0000;
      end else begin
         mem_grant <= mem_req && mem_ok;
         mem_refuse <= mem_req && !mem_ok;
         mem_we_out <= mem_req && mem_wr && mem_ok;
         mem_wdata_out <= mem_wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sfr_grant <= 1'b0;
         sfr_refuse <= 1'b0;
         sfr_rdata <= 16'h0000;
      end else begin
         sfr_grant <= sfr_req && sfr_ok;
         sfr_refuse <= sfr_req && !sfr_ok;
         sfr_rdata <= 16'h0000;
         if (sfr_req && !sfr_wr && sfr_ok) begin
            if (sfr_sel == REG_SEG_BASE) begin
               sfr_rdata <= seg_base_reg;
            end else if (sfr_sel == REG_CSR) begin
               sfr_rdata <= {13'h0000, mode_reg};
            end else if (sfr_sel == REG_XCH_BASE) begin
               sfr_rdata <= xch_base_reg;
            end else if (sfr_sel == REG_XCH_SIZE) begin
               sfr_rdata <= xch_size_reg;
            end else if (sfr_sel == REG_FEAT) begin
               sfr_rdata <= {8'h00, perm_off_reg, feat_reg};
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cpu_mode <= MODE_BOOT;
         seg_table_base <= SEG_BASE_RST;
         xch_base <= XCH_BASE_RST;
         xch_size <= XCH_SIZE_RST;
         ee_size_limit_en <= 1'b0;
         cx_size_limit_en <= 1'b0;
         cipher_en <= 1'b0;
         bignum_en <= 1'b0;
      end else begin
         cpu_mode <= mode_reg;
         seg_table_base <= seg_base_reg;
         xch_base <= xch_base_reg;
         xch_size <= xch_size_reg;
         ee_size_limit_en <= feat_reg[FEAT_EE_SIZE] && !perm_off_reg[FEAT_EE_SIZE];
         cx_size_limit_en <= feat_reg[FEAT_CX_SIZE] && !perm_off_reg[FEAT_CX_SIZE];
         cipher_en <= feat_reg[FEAT_CIPHER] && !perm_off_reg[FEAT_CIPHER];
         bignum_en <= feat_reg[FEAT_BIGNUM] && !perm_off_reg[FEAT_BIGNUM];
      end
   end
endmodule : cmp_mode_ctrl

/* File: hdl/cmp_pkg.sv */
// Purpose: Constants and types for the CPU mode and memory protection block
// Assumes: Single clock, asynchronous active-high reset
// Notes: Address map, modes and control bit positions
// Functional notes
// - Firmware code kept apart from application code
// - Exchange only through small dedicated areas
// - RAM exchange window set by System Mode
// - Integrity function may access whole EEPROM
// - Other firmware confined to firmware EEPROM area
// - System Mode may move and edit table
// - User may edit table in writable segment
// - Table pointer resets to zero, segments off
// - Segmentation registers writable only in System Mode
// - Fixed partition has no configuration path
// - Security attribute writes need mode permission
// - Vector and special call change mode
// - Exception enters mode, return restores it
// - Permitted status register write changes mode
// - Temporary and permanent disable of four features
package cmp_pkg;
   typedef enum logic [2:0] {
      MODE_BOOT = 3'b000,
      MODE_TEST = 3'b001,
      MODE_FW = 3'b010,
      MODE_SYS = 3'b011,
      MODE_USER = 3'b100
   } cmp_mode_t;

   typedef enum logic [2:0] {
      REG_NONE = 3'b000,
      REG_SEG_BASE = 3'b001,
      REG_CSR = 3'b010,
      REG_XCH_BASE = 3'b011,
      REG_XCH_SIZE = 3'b100,
      REG_FEAT = 3'b101
   } cmp_reg_t;

   // Fixed partition bounds (16-bit space)
   localparam logic [15:0] ROM_FW_LO = 16'h0000;
   localparam logic [15:0] ROM_FW_HI = 16'h1fff;
   localparam logic [15:0] ROM_APP_LO = 16'h2000;
   localparam logic [15:0] ROM_APP_HI = 16'h7fff;
   localparam logic [15:0] EE_FW_LO = 16'h8000;
   localparam logic [15:0] EE_FW_HI = 16'h87ff;
   localparam logic [15:0] EE_APP_LO = 16'h8800;
   localparam logic [15:0] EE_APP_HI = 16'hbfff;
   localparam logic [15:0] RAM_FW_LO = 16'hc000;
   localparam logic [15:0] RAM_FW_HI = 16'hc3ff;
   localparam logic [15:0] RAM_APP_LO = 16'hc400;
   localparam logic [15:0] RAM_APP_HI = 16'hffff;

   localparam logic [15:0] SEG_BASE_RST = 16'h0000;
   localparam logic [15:0] XCH_BASE_RST = 16'h0000;
   localparam logic [15:0] XCH_SIZE_RST = 16'h0000;
   localparam logic [15:0] SYS_CALL_VEC = 16'h2000;
   localparam logic [15:0] FW_CALL_VEC = 16'h2004;
   localparam logic [15:0] SPECIAL_CALL_ADDR = 16'h2008;
   localparam logic [15:0] FW_ENTRY_ADDR = 16'h0000;

   localparam int CSR_MODE_LSB = 0;
   localparam int FEAT_EE_SIZE = 0;
   localparam int FEAT_CX_SIZE = 1;
   localparam int FEAT_CIPHER = 2;
   localparam int FEAT_BIGNUM = 3;
   localparam int FEAT_PERM_LSB = 4;
   localparam int STACK_DEPTH = 4;
   localparam int SEG_ENTRIES = 8;
   // Segment entry: [15:13] user rights rwx, [12:0] unused
   localparam int SEG_R_BIT = 15;
   localparam int SEG_W_BIT = 14;
   localparam int SEG_X_BIT = 13;
   localparam logic [3:0] FEAT_RST = 4'hf;
endpackage : cmp_pkg

/* File: sim/cmp_cpu_model.sv */
// Purpose: CPU core model issuing accesses and mode events
// Assumes: Drives at falling edge, answer one edge after taking
// Notes: Released address and data lines show inverted values
`timescale 1ns/10ps
module cmp_cpu_model
   import cmp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic mem_grant,
   input wire logic mem_refuse,
   input wire logic sfr_grant,
   input wire logic sfr_refuse,
   output logic mem_req = 1'b0,
   output logic [15:0] mem_addr = 16'h0000,
   output logic mem_wr = 1'b0,
   output logic mem_fetch = 1'b0,
   output logic [15:0] mem_wdata = 16'h0000,
   output logic integrity_fn = 1'b0,
   output logic [2:0] seg_rights = 3'h7,
   output logic sfr_req = 1'b0,
   output cmp_reg_t sfr_sel = REG_NONE,
   output logic sfr_wr = 1'b0,
   output logic [15:0] sfr_wdata = 16'h0000,
   output logic call_req = 1'b0,
   output logic [15:0] call_target = 16'h0000,
   output logic long_call_instr = 1'b0,
   output logic absolute_call_instr = 1'b0,
   output logic extended_call_instr = 1'b0,
   output logic exc_req = 1'b0,
   output cmp_mode_t exc_mode = MODE_BOOT,
   output logic return_from_interrupt_instr = 1'b0
);
   task automatic mem_acc(input logic [15:0] a, input logic w, input logic [15:0] d,
      input logic f, input logic x, input logic [2:0] u, output logic g, output logic r);
      @(negedge ref_clk);
      {mem_req, mem_addr, mem_wr, mem_wdata, integrity_fn} = {1'b1, a, w, d, f};
      mem_fetch = x;
      seg_rights = u;
      @(posedge ref_clk);
      @(negedge ref_clk);
      {mem_req, mem_addr, mem_wdata, integrity_fn} = {1'b0, ~a, ~d, 1'b0};
      mem_fetch = 1'b0;
      {g, r} = {mem_grant, mem_refuse};
   endtask : mem_acc

   task automatic sfr_acc(input cmp_reg_t s, input logic w, input logic [15:0] d,
      output logic g, output logic r);
      @(negedge ref_clk);
      {sfr_req, sfr_wr, sfr_wdata} = {1'b1, w, d};
      sfr_sel = s;
      @(posedge ref_clk);
      @(negedge ref_clk);
      {sfr_req, sfr_wr, sfr_wdata} = {1'b0, 1'b0, ~d};
      {g, r} = {sfr_grant, sfr_refuse};
   endtask : sfr_acc

   // Kind 0 call, 1 exception, 2 return
   task automatic ctl(input int k, input logic [15:0] t, input logic [2:0] i,
      input cmp_mode_t m);
      @(negedge ref_clk);
      {call_req, exc_req, return_from_interrupt_instr} = {k == 0, k == 1, k == 2};
      call_target = t;
      exc_mode = m;
      {long_call_instr, absolute_call_instr, extended_call_instr} = i;
      @(negedge ref_clk);
      {call_req, exc_req, return_from_interrupt_instr} = 3'h0;
      {long_call_instr, absolute_call_instr, extended_call_instr} = 3'h0;
      call_target = ~t;
   endtask : ctl
endmodule : cmp_cpu_model

/* File: sim/cmp_mode_monitor.sv */
// Purpose: Port-level checks for the CPU mode and protection block
// Assumes: One clock, asynchronous active-high reset
// Notes: Answers are registered, one edge after the request
`timescale 1ns/10ps
module cmp_mode_monitor
   import cmp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic mem_req,
   input wire logic mem_wr,
   input wire logic [15:0] mem_wdata,
   input wire logic sfr_req,
   input wire cmp_reg_t sfr_sel,
   input wire logic sfr_wr,
   input wire logic call_req,
   input wire logic exc_req,
   input wire logic return_from_interrupt_instr,
   input wire logic mem_grant,
   input wire logic mem_refuse,
   input wire logic mem_we_out,
   input wire logic [15:0] mem_wdata_out,
   input wire logic sfr_grant,
   input wire logic sfr_refuse,
   input wire logic [15:0] sfr_rdata,
   input wire cmp_mode_t cpu_mode,
   input wire logic [15:0] seg_table_base
);
   // ------------------------------
   // Checks
   // ------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire logic seg_ev = sfr_req & sfr_wr & (sfr_sel == REG_SEG_BASE);
   wire logic mode_ev = exc_req | return_from_interrupt_instr | call_req |
      (sfr_req & sfr_wr & (sfr_sel == REG_CSR));

   AST_MEM_ANSWER: assert property (mem_req |=> mem_grant ^ mem_refuse)
      else $error("memory request not answered");
   AST_MEM_CAUSE: assert property ((mem_grant | mem_refuse) |-> $past(mem_req))
      else $error("memory answer without request");
   AST_REFUSE_NO_WE: assert property (mem_refuse |-> !mem_we_out)
      else $error("refused access reached memory");
   AST_WE_DATA: assert property (mem_we_out |-> mem_grant && $past(mem_wr) &&
      mem_wdata_out == $past(mem_wdata)) else $error("write strobe or data wrong");
   AST_WRITE_PASSES: assert property (mem_grant && $past(mem_wr) |-> mem_we_out)
      else $error("granted write lost");
   AST_SFR_ANSWER: assert property (sfr_req |=> sfr_grant ^ sfr_refuse)
      else $error("register request not answered");
   AST_SFR_RDATA: assert property (!sfr_grant |-> sfr_rdata == 16'h0000)
      else $error("register data leaked");
   AST_SEG_CAUSE: assert property ($changed(seg_table_base) |->
      $past(seg_ev, 2) || $past(seg_ev, 3)) else $error("table pointer moved alone");
   AST_MODE_CAUSE: assert property ($changed(cpu_mode) |-> $past(mode_ev) ||
      $past(mode_ev, 2) || $past(mode_ev, 3)) else $error("mode changed alone");
endmodule : cmp_mode_monitor

bind cmp_mode_ctrl cmp_mode_monitor mon (.*);

/* File: sim/cpu_mode_memory_protection_tb.sv */
// Purpose: Directed bench for the CPU mode and protection block
// Assumes: Model tasks drive every design input except ref_clk and sys_rst, which the bench drives
// Notes: Checker attached by bind
`timescale 1ns/10ps
module cpu_mode_memory_protection_tb;
   import cmp_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic mem_req, mem_wr, mem_fetch, integrity_fn, sfr_req, sfr_wr, call_req, exc_req;
   logic long_call_instr, absolute_call_instr, extended_call_instr;
   logic return_from_interrupt_instr, mem_grant, mem_refuse, mem_we_out;
   logic sfr_grant, sfr_refuse, ee_size_limit_en, cx_size_limit_en, cipher_en, bignum_en;
   logic [15:0] mem_addr, mem_wdata, sfr_wdata, call_target, mem_wdata_out, sfr_rdata;
   logic [15:0] seg_table_base, xch_base, xch_size;
   logic [2:0] seg_rights;
   cmp_reg_t sfr_sel;
   cmp_mode_t exc_mode, cpu_mode;
   logic g, r;
   logic [2:0] rights = 3'h7;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;

   cmp_mode_ctrl uut (.*);
   cmp_cpu_model cpu (.*);

   always #12.5 ref_clk = ~ref_clk;

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic mem(input logic [15:0] a, input logic w, input logic f, input logic x,
      input logic eg);
      cpu.mem_acc(a, w, a ^ 16'h5a5a, f, x, rights, g, r);
      chk("mem_answer", 16'({g, r}), 16'({eg, ~eg}));
      chk("mem_we", 16'(mem_we_out), 16'(eg && w));
      chk("mem_wdata", mem_wdata_out, a ^ 16'h5a5a);
   endtask : mem

   task automatic sfr(input cmp_reg_t s, input logic w, input logic [15:0] d, input logic eg);
      cpu.sfr_acc(s, w, d, g, r);
      chk("sfr_answer", 16'({g, r}), 16'({eg, ~eg}));
      if (!w) begin
         chk("sfr_rdata", sfr_rdata, eg ? d : 16'h0000);
      end
   endtask : sfr

   task automatic mode_is(input cmp_mode_t m);
      repeat (3) @(negedge ref_clk);
      chk("cpu_mode", 16'(cpu_mode), 16'(m));
   endtask : mode_is

   task automatic feat_is(input logic [15:0] e);
      repeat (2) @(negedge ref_clk);
      chk("features", 16'({bignum_en, cipher_en, cx_size_limit_en, ee_size_limit_en}), e);
   endtask : feat_is

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         end_of_test();
      end
   end

   // ------------------------------
   // Sequence
   // ------------------------------
   initial begin
      repeat (8) @(negedge ref_clk);
      sys_rst = 1'b0;
      feat_is(16'(FEAT_RST));
      chk("seg_base", seg_table_base, SEG_BASE_RST);
      mode_is(MODE_BOOT);
      sfr(REG_SEG_BASE, 1'b1, 16'h1234, 1'b0);
      sfr(REG_NONE, 1'b1, 16'h0001, 1'b0);
      sfr(REG_FEAT, 1'b1, 16'h0005, 1'b1);
      feat_is(16'h0005);
      sfr(REG_FEAT, 1'b1, 16'h001f, 1'b1);
      sfr(REG_FEAT, 1'b1, 16'h000f, 1'b1);
      feat_is(16'h000e);
      sfr(REG_FEAT, 1'b0, 16'h001f, 1'b1);
      sfr(REG_CSR, 1'b1, 16'(MODE_SYS), 1'b1);
      mode_is(MODE_SYS);
      sfr(REG_SEG_BASE, 1'b1, 16'h1234, 1'b1);
      sfr(REG_XCH_BASE, 1'b1, RAM_APP_LO, 1'b1);
      sfr(REG_XCH_SIZE, 1'b1, 16'h0010, 1'b1);
      repeat (2) @(negedge ref_clk);
      chk("seg_base", seg_table_base, 16'h1234);
      chk("xch_base", xch_base, RAM_APP_LO);
      chk("xch_size", xch_size, 16'h0010);
      sfr(REG_SEG_BASE, 1'b0, 16'h1234, 1'b1);
      mem(ROM_FW_LO, 1'b0, 1'b0, 1'b0, 1'b0);
      mem(RAM_APP_LO, 1'b1, 1'b0, 1'b0, 1'b1);
      mem(ROM_APP_LO, 1'b1, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 3; i++) begin
         cpu.ctl(0, SPECIAL_CALL_ADDR, 3'(3'b100 >> i), MODE_BOOT);
         mode_is(MODE_FW);
         cpu.ctl(0, SYS_CALL_VEC, 3'h0, MODE_BOOT);
         mode_is(MODE_SYS);
      end
      cpu.ctl(0, SPECIAL_CALL_ADDR, 3'h0, MODE_BOOT);
      mode_is(MODE_SYS);
      cpu.ctl(0, FW_CALL_VEC, 3'h0, MODE_BOOT);
      mode_is(MODE_FW);
      mem(EE_APP_LO, 1'b1, 1'b0, 1'b0, 1'b0);
      mem(EE_APP_LO, 1'b1, 1'b1, 1'b0, 1'b1);
      mem(EE_APP_LO, 1'b0, 1'b1, 1'b1, 1'b0);
      mem(EE_FW_LO, 1'b1, 1'b0, 1'b0, 1'b1);
      mem(RAM_APP_LO + 16'h000f, 1'b1, 1'b0, 1'b0, 1'b1);
      mem(RAM_APP_LO + 16'h0010, 1'b0, 1'b0, 1'b0, 1'b0);
      mem(RAM_FW_LO, 1'b0, 1'b0, 1'b1, 1'b0);
      sfr(REG_SEG_BASE, 1'b1, 16'h0000, 1'b0);
      sfr(REG_XCH_BASE, 1'b1, 16'h0000, 1'b0);
      sfr(REG_XCH_SIZE, 1'b0, 16'h0010, 1'b1);
      sfr(REG_CSR, 1'b1, 16'(MODE_SYS), 1'b0);
      cpu.ctl(1, 16'h0000, 3'h0, MODE_SYS);
      mode_is(MODE_SYS);
      cpu.ctl(2, 16'h0000, 3'h0, MODE_BOOT);
      mode_is(MODE_FW);
      cpu.ctl(0, SYS_CALL_VEC, 3'h0, MODE_BOOT);
      mode_is(MODE_SYS);
      sfr(REG_CSR, 1'b1, 16'(MODE_USER), 1'b1);
      mode_is(MODE_USER);
      rights = 3'b110;
      mem(EE_APP_LO, 1'b1, 1'b0, 1'b0, 1'b1);
      mem(EE_APP_LO, 1'b0, 1'b0, 1'b1, 1'b0);
      rights = 3'b100;
      mem(EE_APP_LO, 1'b1, 1'b0, 1'b0, 1'b0);
      rights = 3'h7;
      mem(ROM_APP_LO, 1'b1, 1'b0, 1'b0, 1'b0);
      mem(ROM_FW_LO, 1'b0, 1'b0, 1'b0, 1'b0);
      sfr(REG_CSR, 1'b0, 16'(MODE_USER), 1'b1);
      sfr(REG_SEG_BASE, 1'b1, 16'h0000, 1'b0);
      repeat (2) @(negedge ref_clk);
      chk("seg_base", seg_table_base, 16'h1234);
      cpu.ctl(0, SYS_CALL_VEC, 3'h0, MODE_BOOT);
      mode_is(MODE_SYS);
      sfr(REG_SEG_BASE, 1'b1, 16'h0000, 1'b1);
      sfr(REG_CSR, 1'b1, 16'(MODE_USER), 1'b1);
      mode_is(MODE_USER);
      mem(RAM_APP_LO, 1'b0, 1'b0, 1'b0, 1'b0);
      sfr(REG_SEG_BASE, 1'b1, 16'h1234, 1'b0);
      repeat (2) @(negedge ref_clk);
      chk("seg_base", seg_table_base, 16'h0000);
      end_of_test();
   end
endmodule : cpu_mode_memory_protection_tb
